// [hw/epi_map.svh]
`ifndef EPI_MAP_SVH
`define EPI_MAP_SVH
// ****************************************
// register offsets
// ****************************************
`define EPI_ADDR_CTRL 8'h88
`define EPI_ADDR_A_EN 8'h96
`define EPI_ADDR_A_FLAG 8'h97
`define EPI_ADDR_B_EN 8'hAE
`define EPI_ADDR_B_FLAG 8'hAF
`define EPI_ADDR_PRIO 8'hB8
`define EPI_ADDR_A_POL 8'h98
`define EPI_ADDR_B_POL 8'h99
`define EPI_ADDR_LATCH 8'h9A
`define EPI_ADDR_ISTAT 8'h9B
`define EPI_ADDR_IMASK 8'h9C
// ****************************************
// field positions
// ****************************************
`define EPI_CTRL_TF_B 7
`define EPI_CTRL_TR_B 6
`define EPI_CTRL_TF_A 5
`define EPI_CTRL_TR_A 4
`define EPI_CTRL_SUM_B 3
`define EPI_CTRL_SUM_A 1
`define EPI_PRIO_A 0
`define EPI_PRIO_B 2
`define EPI_LATCH_A 0
`define EPI_LATCH_B 1
// ****************************************
// reset values
// ****************************************
`define EPI_RST_REG 8'h00
`define EPI_RST_BIT 1'h0
`define EPI_RST_STAT 4'h0
`endif

// [hw/epi_pkg.sv]
`default_nettype none
package epi_pkg;
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wrStb;
    logic rdStb;
  } epi_bus_s;
  // timer overflow and routine-entry events
  typedef struct packed {
    logic overflowA;
    logic overflowB;
    logic entryA;
    logic entryB;
  } epi_timer_s;
endpackage
`default_nettype wire

// [hw/epi_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
`include "epi_map.svh"
module epi_pin_sync (
  // clock and control
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // pin
  input wire logic pin,
  // edges
  output logic rise,
  output logic fall
);
  logic [2:0] shift;
  logic stable;
  logic primed;
  logic agree;
  logic [1:0] fill;

  // three-stage synchroniser, stage 0 feeds only stage 1
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      shift <= 3'h0;
    end else if (ce) begin
      shift <= {shift[1:0], pin};
    end
  end

  assign agree = (shift[1] == shift[2]);

  // counts the stages loaded since reset, so reset zeros never pass as a pin level
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fill <= 2'h0;
    end else if (ce && (fill != 2'h3)) begin
      fill <= fill + 2'h1;
    end
  end

  // settled level; baseline taken only once every stage holds a real pin sample
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      stable <= `EPI_RST_BIT;
      primed <= `EPI_RST_BIT;
    end else if (ce && agree && (fill == 2'h3)) begin
      stable <= shift[2];
      primed <= 1'h1;
    end
  end

  // one-cycle edge pulses
  assign rise = ce && primed && agree && shift[2] && !stable;
  assign fall = ce && primed && agree && !shift[2] && stable;
endmodule
`default_nettype wire

// [hw/epi_edge_flag.sv]
`timescale 1ns/1ps
`default_nettype none
`include "epi_map.svh"
module epi_edge_flag (
  // clock and control
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // set and clear
  input wire logic setPulse,
  input wire logic clrPulse,
  // latched flag
  output logic flag
);
  // set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      flag <= `EPI_RST_BIT;
    end else if (ce) begin
      if (setPulse) begin
        flag <= 1'h1;
      end else if (clrPulse) begin
        flag <= 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

// [hw/epi_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "epi_map.svh"
module epi_core #(
  parameter int NA = 4,
  parameter int NB = 6
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // register port
  input wire epi_pkg::epi_bus_s bus,
  output logic [7:0] rdData,
  // pins
  input wire logic [NA-1:0] pinsA,
  input wire logic [NB-1:0] pinsB,
  // timer events
  input wire epi_pkg::epi_timer_s timerEv,
  // cpu request lines and priorities
  output logic extIrqA,
  output logic extIrqB,
  output logic extIrqAPriority,
  output logic extIrqBPriority,
  // timer run controls
  output logic timerARun,
  output logic timerBRun,
  // summary interrupt
  output logic irq
);
  // ****************************************
  // declarations
  // ****************************************
  logic [NA-1:0] enA;
  logic [NB-1:0] enB;
  logic [NA-1:0] polA;
  logic [NB-1:0] polB;
  logic [NA-1:0] flagsA;
  logic [NB-1:0] flagsB;
  logic [NA-1:0] setA;
  logic [NB-1:0] setB;
  logic [NA-1:0] riseA;
  logic [NA-1:0] fallA;
  logic [NB-1:0] riseB;
  logic [NB-1:0] fallB;
  logic tfA;
  logic tfB;
  logic [3:0] istat;
  logic [3:0] imask;
  logic [3:0] events;
  logic reqA;
  logic reqB;
  logic sumA;
  logic sumB;
  logic wrCtrl;
  logic wrEnA;
  logic wrFlagA;
  logic wrEnB;
  logic wrFlagB;
  logic wrPolA;
  logic wrPolB;
  logic wrPrio;
  logic wrLatch;
  logic wrIstat;
  logic wrImask;
  logic [7:0] next_rdData;

  // ****************************************
  // address decode
  // ****************************************
  // write strobes, all frozen with the clock enable
  assign wrCtrl = ce && bus.wrStb && (bus.addr == `EPI_ADDR_CTRL);
  assign wrEnA = ce && bus.wrStb && (bus.addr == `EPI_ADDR_A_EN);
  assign wrFlagA = ce && bus.wrStb && (bus.addr == `EPI_ADDR_A_FLAG);
  assign wrEnB = ce && bus.wrStb && (bus.addr == `EPI_ADDR_B_EN);
  assign wrFlagB = ce && bus.wrStb && (bus.addr == `EPI_ADDR_B_FLAG);
  assign wrPolA = ce && bus.wrStb && (bus.addr == `EPI_ADDR_A_POL);
  assign wrPolB = ce && bus.wrStb && (bus.addr == `EPI_ADDR_B_POL);
  assign wrPrio = ce && bus.wrStb && (bus.addr == `EPI_ADDR_PRIO);
  assign wrLatch = ce && bus.wrStb && (bus.addr == `EPI_ADDR_LATCH);
  assign wrIstat = ce && bus.wrStb && (bus.addr == `EPI_ADDR_ISTAT);
  assign wrImask = ce && bus.wrStb && (bus.addr == `EPI_ADDR_IMASK);

  // ****************************************
  // configuration registers
  // ****************************************
  // enables and edge polarities, zero after reset
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      enA <= NA'(`EPI_RST_REG);
      enB <= NB'(`EPI_RST_REG);
      polA <= NA'(`EPI_RST_REG);
      polB <= NB'(`EPI_RST_REG);
    end else begin
      if (wrEnA) begin
        enA <= bus.wrData[NA-1:0];
      end
      if (wrEnB) begin
        enB <= bus.wrData[NB-1:0];
      end
      if (wrPolA) begin
        polA <= bus.wrData[NA-1:0];
      end
      if (wrPolB) begin
        polB <= bus.wrData[NB-1:0];
      end
    end
  end

  // priority bits of the two request lines
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      extIrqAPriority <= `EPI_RST_BIT;
      extIrqBPriority <= `EPI_RST_BIT;
    end else if (wrPrio) begin
      extIrqAPriority <= bus.wrData[`EPI_PRIO_A];
      extIrqBPriority <= bus.wrData[`EPI_PRIO_B];
    end
  end

  // ****************************************
  // pin edge detection and flags
  // ****************************************
  // one synchroniser and flag per group A pin
  for (genvar i = 0; i < NA; i++) begin : gA
    epi_pin_sync uSync (
      .mclk(mclk),
      .reset_n(reset_n),
      .ce(ce),
      .pin(pinsA[i]),
      .rise(riseA[i]),
      .fall(fallA[i])
    );
    // polarity bit high selects rising edge
    assign setA[i] = polA[i] ? riseA[i] : fallA[i];
    epi_edge_flag uFlag (
      .mclk(mclk),
      .reset_n(reset_n),
      .ce(ce),
      .setPulse(setA[i]),
      .clrPulse(wrFlagA && !bus.wrData[i]),
      .flag(flagsA[i])
    );
  end

  // one synchroniser and flag per group B pin
  for (genvar j = 0; j < NB; j++) begin : gB
    epi_pin_sync uSync (
      .mclk(mclk),
      .reset_n(reset_n),
      .ce(ce),
      .pin(pinsB[j]),
      .rise(riseB[j]),
      .fall(fallB[j])
    );
    // polarity clear after reset gives falling edge
    assign setB[j] = polB[j] ? riseB[j] : fallB[j];
    epi_edge_flag uFlag (
      .mclk(mclk),
      .reset_n(reset_n),
      .ce(ce),
      .setPulse(setB[j]),
      .clrPulse(wrFlagB && !bus.wrData[j]),
      .flag(flagsB[j])
    );
  end

  // ****************************************
  // group requests
  // ****************************************
  // summary mirrors all flags, request only enabled ones
  assign sumA = |flagsA;
  assign sumB = |flagsB;
  assign reqA = |(flagsA & enA);
  assign reqB = |(flagsB & enB);

  // latched request lines; a live request wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      extIrqA <= `EPI_RST_BIT;
      extIrqB <= `EPI_RST_BIT;
    end else if (ce) begin
      if (reqA) begin
        extIrqA <= 1'h1;
      end else if (wrLatch && bus.wrData[`EPI_LATCH_A]) begin
        extIrqA <= 1'h0;
      end
      if (reqB) begin
        extIrqB <= 1'h1;
      end else if (wrLatch && bus.wrData[`EPI_LATCH_B]) begin
        extIrqB <= 1'h0;
      end
    end
  end

  // ****************************************
  // timer flags and run bits
  // ****************************************
  // overflow sets, routine entry clears, set wins
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tfA <= `EPI_RST_BIT;
      tfB <= `EPI_RST_BIT;
    end else if (ce) begin
      if (timerEv.overflowA) begin
        tfA <= 1'h1;
      end else if (timerEv.entryA) begin
        tfA <= 1'h0;
      end
      if (timerEv.overflowB) begin
        tfB <= 1'h1;
      end else if (timerEv.entryB) begin
        tfB <= 1'h0;
      end
    end
  end

  // run bits are the only writable control fields
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      timerARun <= `EPI_RST_BIT;
      timerBRun <= `EPI_RST_BIT;
    end else if (wrCtrl) begin
      timerARun <= bus.wrData[`EPI_CTRL_TR_A];
      timerBRun <= bus.wrData[`EPI_CTRL_TR_B];
    end
  end

  // ****************************************
  // interrupt status and mask
  // ****************************************
  // events: pin A edge, pin B edge, timer A, timer B overflow
  assign events = {timerEv.overflowB, timerEv.overflowA, |setB, |setA};

  // sticky status, write one to clear, set wins
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      istat <= `EPI_RST_STAT;
      imask <= `EPI_RST_STAT;
    end else if (ce) begin
      istat <= (istat & ~(wrIstat ? bus.wrData[3:0] : 4'h0)) | events;
      if (wrImask) begin
        imask <= bus.wrData[3:0];
      end
    end
  end

  // level interrupt while an unmasked status bit is set
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq <= `EPI_RST_BIT;
    end else if (ce) begin
      irq <= |(istat & imask);
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // read mux, unmapped addresses return zero
  always_comb begin
    next_rdData = 8'h00;
    unique case (bus.addr)
      `EPI_ADDR_CTRL: begin
        next_rdData[`EPI_CTRL_TF_B] = tfB;
        next_rdData[`EPI_CTRL_TR_B] = timerBRun;
        next_rdData[`EPI_CTRL_TF_A] = tfA;
        next_rdData[`EPI_CTRL_TR_A] = timerARun;
        next_rdData[`EPI_CTRL_SUM_B] = sumB;
        next_rdData[`EPI_CTRL_SUM_A] = sumA;
      end
      `EPI_ADDR_A_EN: next_rdData = 8'(enA);
      `EPI_ADDR_A_FLAG: next_rdData = 8'(flagsA);
      `EPI_ADDR_B_EN: next_rdData = 8'(enB);
      `EPI_ADDR_B_FLAG: next_rdData = 8'(flagsB);
      `EPI_ADDR_A_POL: next_rdData = 8'(polA);
      `EPI_ADDR_B_POL: next_rdData = 8'(polB);
      `EPI_ADDR_PRIO: begin
        next_rdData[`EPI_PRIO_A] = extIrqAPriority;
        next_rdData[`EPI_PRIO_B] = extIrqBPriority;
      end
      `EPI_ADDR_LATCH: begin
        next_rdData[`EPI_LATCH_A] = extIrqA;
        next_rdData[`EPI_LATCH_B] = extIrqB;
      end
      `EPI_ADDR_ISTAT: next_rdData = {4'h0, istat};
      `EPI_ADDR_IMASK: next_rdData = {4'h0, imask};
      default: next_rdData = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdData <= `EPI_RST_REG;
    end else if (ce) begin
      rdData <= bus.rdStb ? next_rdData : 8'h00;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cbClk @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // an enabled flag is present while running
  sequence seqReqA;
    ce && reqA;
  endsequence

  // software clears the latch while the request lives
  sequence seqLatchClrA;
    wrLatch && bus.wrData[`EPI_LATCH_A];
  endsequence

  AST_FLAG_HOLD:
    assert property (ce && !wrFlagA |=> (flagsA & $past(flagsA)) == $past(flagsA))
    else $error("group A flag dropped without a clear write");

  AST_EDGE_SET_A:
    assert property (ce && setA[0] |=> flagsA[0])
    else $error("group A edge did not set its flag");

  AST_EDGE_SET_B:
    assert property (ce && setB[0] |=> flagsB[0] ##1 flagsB[0] || !$past(wrFlagB))
    else $error("group B edge did not set its flag");

  AST_SUM_READ:
    assert property (ce && bus.rdStb && bus.addr == `EPI_ADDR_CTRL
                     |=> rdData[`EPI_CTRL_SUM_B] == $past(sumB))
    else $error("summary flag read does not mirror group B flags");

  AST_TF_WRITE_IGNORED:
    assert property (wrCtrl && !timerEv.overflowA && !timerEv.entryA |=> tfA == $past(tfA))
    else $error("control write changed a timer flag");

  AST_REQ_RAISE:
    assert property (seqReqA |=> extIrqA ##1 (extIrqA || !ce || !$past(reqA)))
    else $error("group A request not raised");

  AST_REQ_RELOAD:
    assert property (seqReqA and seqLatchClrA |=> extIrqA)
    else $error("live group A request lost on latch clear");

  AST_NO_REQ_DISABLED:
    assert property (ce && !reqA && !extIrqA |=> !extIrqA)
    else $error("request raised with no enabled flag");

  AST_TF_CLEAR:
    assert property (ce && timerEv.entryA && !timerEv.overflowA |=> !tfA)
    else $error("timer A flag not cleared on routine entry");

  AST_RUN_WRITE:
    assert property (wrCtrl |=> timerARun == $past(bus.wrData[`EPI_CTRL_TR_A])
                     && timerBRun == $past(bus.wrData[`EPI_CTRL_TR_B]))
    else $error("run bits do not follow the control write");

  AST_PRIO_WRITE:
    assert property (wrPrio |=> extIrqBPriority == $past(bus.wrData[`EPI_PRIO_B]))
    else $error("priority bit does not follow the write");
endmodule
`default_nettype wire

// [verif/epi_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// external pin sources
// ****************************************
module epi_pin_model #(
  parameter int NA = 4,
  parameter int NB = 6
) (
  // clock
  input wire logic mclk,
  // pins
  output var logic [NA-1:0] pinsA,
  output var logic [NB-1:0] pinsB
);
  // pins idle high so that a first toggle is a falling edge
  initial begin
    pinsA = '1;
    pinsB = '1;
  end

  // toggle one group A pin, then hold it long enough to be sampled and latched
  task automatic flipA(input int i);
    @(posedge mclk);
    pinsA[i] <= ~pinsA[i];
    repeat (8) @(posedge mclk);
  endtask

  // toggle one group B pin, then hold it long enough to be sampled and latched
  task automatic flipB(input int i);
    @(posedge mclk);
    pinsB[i] <= ~pinsB[i];
    repeat (8) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "epi_map.svh"
module testbench;
  // ****************************************
  // signals
  // ****************************************
  logic mclk;
  logic reset_n;
  logic ce;
  epi_pkg::epi_bus_s bus;
  epi_pkg::epi_timer_s tev;
  logic [7:0] rdData;
  logic [3:0] pinsA;
  logic [5:0] pinsB;
  logic extIrqA, extIrqB, extIrqAPriority, extIrqBPriority, timerARun, timerBRun, irq;
  int errTotal;
  int checkCount;
  logic [7:0] rdVal;
  logic [7:0] addrList [12] = '{`EPI_ADDR_CTRL, `EPI_ADDR_A_EN, `EPI_ADDR_A_FLAG, `EPI_ADDR_B_EN,
    `EPI_ADDR_B_FLAG, `EPI_ADDR_PRIO, `EPI_ADDR_A_POL, `EPI_ADDR_B_POL, `EPI_ADDR_LATCH,
    `EPI_ADDR_ISTAT, `EPI_ADDR_IMASK, 8'h00};

  // design and pin sources
  epi_core dut (.mclk(mclk), .reset_n(reset_n), .ce(ce), .bus(bus), .rdData(rdData),
    .pinsA(pinsA), .pinsB(pinsB), .timerEv(tev), .extIrqA(extIrqA), .extIrqB(extIrqB),
    .extIrqAPriority(extIrqAPriority), .extIrqBPriority(extIrqBPriority), .timerARun(timerARun),
    .timerBRun(timerBRun), .irq(irq));
  epi_pin_model pins (.mclk(mclk), .pinsA(pinsA), .pinsB(pinsB));

  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ****************************************
  // access tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
    @(posedge mclk);
    bus.wrStb <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    bus <= '{addr: a, wrData: 8'h00, wrStb: 1'b0, rdStb: 1'b1};
    @(posedge mclk);
    bus.rdStb <= 1'b0;
    #1;
    rdVal = rdData;
  endtask

  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk($sformatf("reg %h", a), rdVal, exp);
  endtask

  // one-cycle timer event pulse
  task automatic tmr(input logic [3:0] ev);
    @(posedge mclk);
    tev <= epi_pkg::epi_timer_s'(ev);
    @(posedge mclk);
    tev <= '0;
  endtask

  task automatic hold;
    repeat (8) @(posedge mclk);
  endtask

  task automatic closeOut;
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    errTotal = 0;
    checkCount = 0;
    ce = 1'b1;
    reset_n = 1'b0;
    bus = '0;
    tev = '0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    // reset values, unmapped address included
    for (int i = 0; i < 12; i++) begin
      rc(addrList[i], 8'h00);
    end
    chk("extIrqA", extIrqA, 8'h00);
    chk("irq", irq, 8'h00);
    // register widths and read-only fields
    wr(`EPI_ADDR_A_EN, 8'hFF);
    rc(`EPI_ADDR_A_EN, 8'h0F);
    wr(`EPI_ADDR_B_EN, 8'hFF);
    rc(`EPI_ADDR_B_EN, 8'h3F);
    wr(`EPI_ADDR_PRIO, 8'hFF);
    rc(`EPI_ADDR_PRIO, 8'h05);
    chk("prio", {extIrqBPriority, extIrqAPriority}, 8'h03);
    wr(`EPI_ADDR_PRIO, 8'h00);
    wr(`EPI_ADDR_CTRL, 8'hFF);
    rc(`EPI_ADDR_CTRL, 8'h50);
    chk("run", {timerBRun, timerARun}, 8'h03);
    wr(`EPI_ADDR_CTRL, 8'h00);
    @(posedge mclk);
    chk("run", {timerBRun, timerARun}, 8'h00);
    // strobes with clock enable low are dropped
    @(posedge mclk);
    ce <= 1'b0;
    wr(`EPI_ADDR_A_EN, 8'h00);
    @(posedge mclk);
    ce <= 1'b1;
    rc(`EPI_ADDR_A_EN, 8'h0F);
    wr(`EPI_ADDR_A_EN, 8'h00);
    wr(`EPI_ADDR_B_EN, 8'h00);
    // group A edge latched while disabled, then enabled
    pins.flipA(2);
    rc(`EPI_ADDR_A_FLAG, 8'h04);
    chk("extIrqA", extIrqA, 8'h00);
    rc(`EPI_ADDR_CTRL, 8'h02);
    rc(`EPI_ADDR_ISTAT, 8'h01);
    chk("irq", irq, 8'h00);
    wr(`EPI_ADDR_A_EN, 8'h04);
    hold();
    chk("extIrqA", extIrqA, 8'h01);
    wr(`EPI_ADDR_IMASK, 8'h01);
    hold();
    chk("irq", irq, 8'h01);
    wr(`EPI_ADDR_ISTAT, 8'h01);
    hold();
    chk("irq", irq, 8'h00);
    rc(`EPI_ADDR_ISTAT, 8'h00);
    wr(`EPI_ADDR_IMASK, 8'h00);
    wr(`EPI_ADDR_A_FLAG, 8'h0B);
    rc(`EPI_ADDR_A_FLAG, 8'h00);
    pins.flipA(2);
    rc(`EPI_ADDR_A_FLAG, 8'h00);
    wr(`EPI_ADDR_LATCH, 8'h01);
    hold();
    chk("extIrqA", extIrqA, 8'h00);
    rc(`EPI_ADDR_LATCH, 8'h00);
    // rising edge selected on one group A pin
    wr(`EPI_ADDR_A_POL, 8'h02);
    pins.flipA(1);
    rc(`EPI_ADDR_A_FLAG, 8'h00);
    pins.flipA(1);
    rc(`EPI_ADDR_A_FLAG, 8'h02);
    chk("extIrqA", extIrqA, 8'h00);
    wr(`EPI_ADDR_A_FLAG, 8'h00);
    wr(`EPI_ADDR_A_POL, 8'h00);
    // group B falling edge only
    pins.flipB(5);
    rc(`EPI_ADDR_B_FLAG, 8'h20);
    rc(`EPI_ADDR_CTRL, 8'h08);
    rc(`EPI_ADDR_ISTAT, 8'h03);
    wr(`EPI_ADDR_B_EN, 8'h20);
    hold();
    chk("extIrqB", extIrqB, 8'h01);
    wr(`EPI_ADDR_B_FLAG, 8'h00);
    pins.flipB(5);
    rc(`EPI_ADDR_B_FLAG, 8'h00);
    wr(`EPI_ADDR_LATCH, 8'h02);
    hold();
    chk("extIrqB", extIrqB, 8'h00);
    rc(`EPI_ADDR_CTRL, 8'h00);
    // every pin of both groups has its own flag
    for (int i = 0; i < 4; i++) begin
      pins.flipA(i);
      pins.flipA(i);
    end
    for (int i = 0; i < 6; i++) begin
      pins.flipB(i);
      pins.flipB(i);
    end
    rc(`EPI_ADDR_A_FLAG, 8'h0F);
    rc(`EPI_ADDR_B_FLAG, 8'h3F);
    // pending flags re-raise the request until each is cleared
    wr(`EPI_ADDR_A_EN, 8'h0F);
    wr(`EPI_ADDR_A_FLAG, 8'h0E);
    wr(`EPI_ADDR_LATCH, 8'h01);
    hold();
    chk("extIrqA", extIrqA, 8'h01);
    rc(`EPI_ADDR_A_FLAG, 8'h0E);
    wr(`EPI_ADDR_A_FLAG, 8'h00);
    wr(`EPI_ADDR_LATCH, 8'h01);
    wr(`EPI_ADDR_B_FLAG, 8'h00);
    wr(`EPI_ADDR_LATCH, 8'h02);
    hold();
    chk("extIrq", {extIrqB, extIrqA}, 8'h00);
    // timer overflow set and routine-entry clear
    wr(`EPI_ADDR_ISTAT, 8'h0F);
    tmr(4'h8);
    rc(`EPI_ADDR_CTRL, 8'h20);
    rc(`EPI_ADDR_ISTAT, 8'h04);
    wr(`EPI_ADDR_IMASK, 8'h04);
    hold();
    chk("irq", irq, 8'h01);
    tmr(4'h2);
    rc(`EPI_ADDR_CTRL, 8'h00);
    wr(`EPI_ADDR_ISTAT, 8'h04);
    hold();
    chk("irq", irq, 8'h00);
    tmr(4'h5);
    rc(`EPI_ADDR_CTRL, 8'h80);
    rc(`EPI_ADDR_ISTAT, 8'h08);
    tmr(4'h1);
    rc(`EPI_ADDR_CTRL, 8'h00);
    closeOut();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    errTotal++;
    closeOut();
  end
endmodule
`default_nettype wire
